// [src/supervisor_pkg.sv]
package supervisor_pkg;
    // Clock rate
    localparam longint CLK_HZ          = 64'd50000000;
    // Watchdog interval in milliseconds
    localparam longint WDOG_MS         = 64'd1600;
    // Reset timeout in milliseconds
    localparam longint RST_TIMEOUT_MS  = 64'd200;
    // Manual reset debounce time in microseconds
    localparam longint DEBOUNCE_US     = 64'd10000;
    // Derived cycle counts, all three round down
    localparam longint WDOG_CYCLES     = (CLK_HZ * WDOG_MS) / 64'd1000;
    localparam longint RST_CYCLES      = (CLK_HZ * RST_TIMEOUT_MS) / 64'd1000;
    localparam longint DEBOUNCE_CYCLES = (CLK_HZ * DEBOUNCE_US) / 64'd1000000;
    // Memory geometry
    localparam int     MEM_BITS        = 2048;
    localparam int     PAGE_BYTES      = 16;
    // Counter width
    localparam int     CNT_W           = 32;
endpackage

// [src/supervisor_reset_watchdog.sv]
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
    parameter longint WDOG_CYCLES     = supervisor_pkg::WDOG_CYCLES,
    parameter longint RST_CYCLES      = supervisor_pkg::RST_CYCLES,
    parameter longint DEBOUNCE_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES,
    parameter bit     KICK_FROM_SDA   = 1'b0,
    parameter int     MEM_BITS        = supervisor_pkg::MEM_BITS,
    parameter int     PAGE_BYTES      = supervisor_pkg::PAGE_BYTES
) (
    input  wire logic CLK_SYS,            // System clock
    input  wire logic RST,                // Asynchronous reset
    input  wire logic UNDERVOLTAGE,       // Supply below threshold
    input  wire logic MANUAL_RESET_IN_N,  // Manual reset, low active
    input  wire logic WATCHDOG_KICK_IN,   // Watchdog kick input
    input  wire logic SDA_IN,             // Serial data line level
    input  wire logic RESET_PIN_N_IN,     // Level seen on reset pin
    input  wire logic WRITE_PROTECT,      // Write protect input
    input  wire logic WRITE_REQ,          // Memory write request
    output logic      RESET_OUT,          // Active high reset
    output logic      RESET_PIN_N_OUT,    // Drive value of reset pin
    output logic      RESET_PIN_N_OE,     // Drives reset pin low
    output logic      WRITE_ALLOW,        // Memory write permitted
    output logic      WDOG_EXPIRED        // Watchdog caused reset
);
    // Refuse timing counts that the counters cannot hold
    if (WDOG_CYCLES < 2 || RST_CYCLES < 2 || DEBOUNCE_CYCLES < 1 ||
        WDOG_CYCLES >= 64'h0000_0000_ffff_ffff ||
        RST_CYCLES >= 64'h0000_0000_ffff_ffff ||
        DEBOUNCE_CYCLES >= 64'h0000_0000_ffff_ffff) begin : g_bad_timing
        $error("supervisor: bad timing parameter");
    end
    // Array geometry is fixed
    if (MEM_BITS != 2048 || PAGE_BYTES != 16) begin : g_bad_geometry
        $error("supervisor: bad memory geometry");
    end

    localparam int W = supervisor_pkg::CNT_W;
    localparam logic [W-1:0] WDOG_MAX = W'(WDOG_CYCLES - 1);
    localparam logic [W-1:0] RST_MAX  = W'(RST_CYCLES - 1);
    localparam logic [W-1:0] DEB_MAX  = W'(DEBOUNCE_CYCLES - 1);

    // Whole state of the block
    typedef struct packed {
        logic         kick_prev;  // Last kick level
        logic         mr_stable;  // Debounced manual reset level
        logic [W-1:0] deb_cnt;    // Debounce counter
        logic [W-1:0] wd_cnt;     // Watchdog interval counter
        logic         wd_fire;    // Watchdog timeout pending
        logic [W-1:0] hold_cnt;   // Reset timeout counter
        logic         in_reset;   // Reset outputs asserted
        logic         rst_out;    // Active high output
        logic         pin_oe;     // Pin pulled low
        logic         wr_allow;   // Write gate
        logic         wd_flag;    // Watchdog expired since last manual reset
    } state_t;

    state_t st_reg;   // Registered state
    state_t st_next;  // Next state

    logic kick_lvl;   // Selected activity source
    logic kick_edge;  // Any edge on activity
    logic cause;      // Any reset cause active

    // Source selection and cause merge
    always_comb begin
        kick_lvl  = KICK_FROM_SDA ? SDA_IN : WATCHDOG_KICK_IN;
        kick_edge = kick_lvl != st_reg.kick_prev;
        // External pull-down on the pin while we are not driving counts
        cause     = UNDERVOLTAGE || !st_reg.mr_stable ||
                    (!RESET_PIN_N_IN && !st_reg.pin_oe) ||
                    st_reg.wd_fire;
    end

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.kick_prev = kick_lvl;
        // Debounce: new level must stand for the whole window
        if (MANUAL_RESET_IN_N == st_reg.mr_stable) begin
            st_next.deb_cnt = '0;
        end else if (st_reg.deb_cnt == DEB_MAX) begin
            st_next.mr_stable = MANUAL_RESET_IN_N;
            st_next.deb_cnt   = '0;
        end else begin
            st_next.deb_cnt = st_reg.deb_cnt + W'(1);
        end
        // Reset hold: any cause reloads the full timeout
        if (cause) begin
            st_next.in_reset = 1'b1;
            st_next.hold_cnt = '0;
            st_next.wd_fire  = 1'b0;
        end else if (st_reg.in_reset) begin
            if (st_reg.hold_cnt == RST_MAX) begin
                st_next.in_reset = 1'b0;
            end else begin
                st_next.hold_cnt = st_reg.hold_cnt + W'(1);
            end
        end
        // Watchdog counts only while outputs released
        if (st_reg.in_reset || cause || kick_edge) begin
            st_next.wd_cnt = '0;
        end else if (st_reg.wd_cnt == WDOG_MAX) begin
            st_next.wd_fire = 1'b1;
            st_next.wd_flag = 1'b1;
            st_next.wd_cnt  = '0;
        end else begin
            st_next.wd_cnt = st_reg.wd_cnt + W'(1);
        end
        // Flag clears on a stable manual reset with supply good
        if (!UNDERVOLTAGE && !st_reg.mr_stable)
            st_next.wd_flag = 1'b0;
        // Reset outputs follow hold state together
        st_next.rst_out  = st_next.in_reset;
        st_next.pin_oe   = st_next.in_reset;
        st_next.wr_allow = !UNDERVOLTAGE && !WRITE_PROTECT;
    end

    // State register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_reg <= '{kick_prev: 1'b0, mr_stable: 1'b1, deb_cnt: '0,
                        wd_cnt: '0, wd_fire: 1'b0, hold_cnt: '0,
                        in_reset: 1'b1, rst_out: 1'b1, pin_oe: 1'b1,
                        wr_allow: 1'b0, wd_flag: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops, except the pin drive value, which is tied low
    assign RESET_OUT       = st_reg.rst_out;
    assign RESET_PIN_N_OUT = 1'b0;  // Open drain: only ever drives low
    assign RESET_PIN_N_OE  = st_reg.pin_oe;
    assign WRITE_ALLOW     = st_reg.wr_allow;
    assign WDOG_EXPIRED    = st_reg.wd_flag;

    // Checks watch registered outputs and internal state, one clock only
    // Four antecedents that look one cycle ahead (gate open, both count steps, flag clear) skip the reset release edge

    // Write gate checks
    // Gate follows the inputs one cycle late
    // Write gate is low one cycle after undervoltage
    uv_blocks_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        UNDERVOLTAGE |=> !WRITE_ALLOW)
        else $error("write allowed in undervoltage");

    // Protect pin blocks writes
    wp_blocks_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        WRITE_PROTECT |=> !WRITE_ALLOW)
        else $error("write allowed while protected");

    // Gate opens with good supply and no protect
    wa_open_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!RST && !UNDERVOLTAGE && !WRITE_PROTECT)
        |=> WRITE_ALLOW)
        else $error("write refused without cause");

    // Open gate implies good supply a cycle ago
    wa_needs_good_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        WRITE_ALLOW |-> $past(!UNDERVOLTAGE && !WRITE_PROTECT))
        else $error("write gate opened without cause");

    // Reset output checks
    // Every cause restarts the full hold
    // Reset output and pin enable always equal
    outputs_paired_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RESET_OUT == RESET_PIN_N_OE)
        else $error("reset outputs disagree");

    // Undervoltage asserts reset next cycle
    uv_asserts_reset_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        UNDERVOLTAGE |=> RESET_OUT)
        else $error("no reset on undervoltage");

    // Undervoltage pulls the pin low next cycle
    uv_drives_pin_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        UNDERVOLTAGE |=> RESET_PIN_N_OE)
        else $error("pin not driven in undervoltage");

    // Debounced manual reset asserts reset
    mr_holds_reset_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !st_reg.mr_stable |=> RESET_OUT)
        else $error("no reset on manual reset");

    // External pin pull triggers reset
    pin_trigger_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!RESET_PIN_N_IN && !RESET_PIN_N_OE)
        |=> RESET_OUT)
        else $error("external pin low ignored");

    // Release only after full hold count
    hold_full_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RESET_OUT)
        |-> $past(st_reg.hold_cnt) == RST_MAX)
        else $error("reset released early");

    // Reset stays while the hold count runs
    no_early_release_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (RESET_OUT && st_reg.hold_cnt != RST_MAX)
        |=> RESET_OUT)
        else $error("reset dropped mid hold");

    // Release only after a quiet cycle
    release_quiet_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RESET_OUT) |-> !$past(cause))
        else $error("reset released with cause active");

    // Any cause reloads the hold
    hold_reload_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        cause
        |=> (st_reg.in_reset && st_reg.hold_cnt == '0))
        else $error("hold not reloaded by cause");

    // Hold count steps by one while quiet
    hold_counts_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!RST && st_reg.in_reset && !cause && st_reg.hold_cnt != RST_MAX)
        |=> (st_reg.in_reset && st_reg.hold_cnt == $past(st_reg.hold_cnt) + W'(1)))
        else $error("hold count skipped");

    // Hold count never passes its end
    hold_limit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.hold_cnt <= RST_MAX)
        else $error("hold count overran");

    // Debounce checks
    // A high input keeps the stable level high
    mr_stays_high_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (MANUAL_RESET_IN_N && st_reg.mr_stable)
        |=> st_reg.mr_stable)
        else $error("manual reset level flipped");

    // A low input keeps the stable level low
    mr_stays_low_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!MANUAL_RESET_IN_N && !st_reg.mr_stable)
        |=> !st_reg.mr_stable)
        else $error("manual reset released early");

    // Debounce count never passes its end
    deb_limit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.deb_cnt <= DEB_MAX)
        else $error("debounce count overran");

    // Watchdog checks
    // Expiry asserts reset two cycles later
    wdog_fires_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!cause && !st_reg.in_reset && !kick_edge && st_reg.wd_cnt == WDOG_MAX)
        |-> ##2 RESET_OUT) else $error("watchdog expiry missed");

    // Watchdog idle during reset
    wdog_idle_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.in_reset |=> st_reg.wd_cnt == '0)
        else $error("watchdog ran in reset");

    // Any edge on the selected source restarts the interval
    kick_clears_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        kick_edge |=> st_reg.wd_cnt == '0)
        else $error("kick edge ignored");

    // Interval counter steps by one while released
    wd_counts_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!RST && !cause && !st_reg.in_reset && !kick_edge && st_reg.wd_cnt != WDOG_MAX)
        |=> st_reg.wd_cnt == $past(st_reg.wd_cnt) + W'(1))
        else $error("watchdog count skipped");

    // Interval counter never passes its end
    wd_limit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.wd_cnt <= WDOG_MAX)
        else $error("watchdog count overran");

    // Pending expiry asserts reset next cycle
    fire_resets_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.wd_fire |=> RESET_OUT)
        else $error("expiry did not reset");

    // Pending expiry is reported
    fire_flags_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        st_reg.wd_fire |-> WDOG_EXPIRED)
        else $error("expiry not flagged");

    // Stable manual reset with good supply clears the flag
    flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!RST && !UNDERVOLTAGE && !st_reg.mr_stable)
        |=> !WDOG_EXPIRED)
        else $error("expiry flag not cleared");

    // Interval starts fresh on release
    released_idle_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RESET_OUT) |-> st_reg.wd_cnt == '0)
        else $error("watchdog not restarted on release");
endmodule

// [test/kick_partner.sv]
`timescale 1ns/1ps
// System side: toggles the kick input while running
module kick_partner (
    input  wire logic clk,   // System clock
    input  wire logic run,   // Kicking enabled
    input  wire logic slow,  // Long gap between kicks
    output logic      kick   // Kick level
);
    int gap = 0;  // Cycles to next toggle
    initial kick = 1'b0;
    // Toggle well inside the watchdog interval
    always @(posedge clk) begin
        if (run && gap == 0) begin
            kick <= ~kick;
            gap  <= slow ? 40 : 5;
        end else if (gap > 0) begin
            gap <= gap - 1;
        end
    end
endmodule

// [test/supervisor_reset_watchdog_tb_top.sv]
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, uv = 1'b0, mr_n = 1'b1, ext_n = 1'b1;
    logic wp = 1'b0, wreq = 1'b0, sda = 1'b1, run = 1'b1, slow = 1'b0;
    logic kick, r_out, p_out, p_oe, w_allow, wd_exp, pin_n;
    int   seed = 32'hc18bc0ff, num_errors = 0, checks_done = 0;
    // Open-drain pin: ours when enabled, else the outside agent
    assign pin_n = p_oe ? p_out : ext_n;
    always #10 clk_sys = ~clk_sys;
    kick_partner PART (.clk(clk_sys), .run(run), .slow(slow), .kick(kick));
    supervisor_reset_watchdog #(.WDOG_CYCLES(50), .RST_CYCLES(20), .DEBOUNCE_CYCLES(3)) DUT (
        .CLK_SYS(clk_sys), .RST(rst), .UNDERVOLTAGE(uv), .MANUAL_RESET_IN_N(mr_n),
        .WATCHDOG_KICK_IN(kick), .SDA_IN(sda), .RESET_PIN_N_IN(pin_n),
        .WRITE_PROTECT(wp), .WRITE_REQ(wreq), .RESET_OUT(r_out),
        .RESET_PIN_N_OUT(p_out), .RESET_PIN_N_OE(p_oe), .WRITE_ALLOW(w_allow),
        .WDOG_EXPIRED(wd_exp));
    // Wait whole cycles
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Compare one settled value
    task chk(input string nm, input logic seen, input logic exp);
        #1;
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    // Counts and verdict
    task complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    initial begin
        cyc(5000);
        num_errors++;
        complete_run;
    end
    // Main sequence
    initial begin
        cyc(5);
        rst <= 1'b0;
        cyc(3);
        chk("out", r_out, 1'b1);
        cyc(30);
        chk("out", r_out, 1'b0);
        $display("power-up done");
        uv <= 1'b1;
        cyc(2);
        chk("out", r_out, 1'b1);
        chk("oe", p_oe, 1'b1);
        chk("pin", p_out, 1'b0);
        chk("wa", w_allow, 1'b0);
        uv <= 1'b0;
        cyc(12);
        chk("out", r_out, 1'b1);
        cyc(20);
        chk("out", r_out, 1'b0);
        $display("undervoltage done");
        for (int i = 0; i < 8; i++) begin
            wp   <= 1'($random(seed));
            wreq <= 1'($random(seed));
            sda  <= 1'($random(seed));
            cyc(2);
            chk("wa", w_allow, !wp);
        end
        wp <= 1'b0;
        $display("protect done");
        mr_n <= 1'b0;
        cyc(1);
        mr_n <= 1'b1;
        cyc(5);
        chk("out", r_out, 1'b0);
        mr_n <= 1'b0;
        cyc(10);
        chk("out", r_out, 1'b1);
        mr_n <= 1'b1;
        cyc(12);
        chk("out", r_out, 1'b1);
        cyc(25);
        chk("out", r_out, 1'b0);
        $display("manual done");
        ext_n <= 1'b0;
        cyc(2);
        chk("out", r_out, 1'b1);
        ext_n <= 1'b1;
        cyc(40);
        chk("out", r_out, 1'b0);
        $display("pin done");
        slow <= 1'b1;
        cyc(200);
        chk("out", r_out, 1'b0);
        run <= 1'b0;
        // Expiry time depends on where the last kick fell
        for (int i = 0; i < 110 && r_out !== 1'b1; i++)
            cyc(1);
        chk("out", r_out, 1'b1);
        chk("wdx", wd_exp, 1'b1);
        run <= 1'b1;
        slow <= 1'b0;
        cyc(90);
        chk("out", r_out, 1'b0);
        $display("watchdog done");
        complete_run;
    end
endmodule
